// [hdl/tpbs_defines.vh]
// constants for the table push and bit shift unit
`ifndef TPBS_DEFINES_VH
`define TPBS_DEFINES_VH
// ==========================================================
// register word indexes on the plain register port
`define TPBS_REG_CMD 4'h0
`define TPBS_REG_ACC 4'h1
`define TPBS_REG_STK1 4'h2
`define TPBS_REG_SRC 4'h3
`define TPBS_REG_SHCNT 4'h4
`define TPBS_REG_FLAGS 4'h5
`define TPBS_REG_INT_STAT 4'h6
`define TPBS_REG_INT_MASK 4'h7
`define TPBS_REG_MEM_ADDR 4'h8
`define TPBS_REG_MEM_DATA 4'h9
// ==========================================================
// command bits
`define TPBS_CMD_PUSH 0
`define TPBS_CMD_SHL 1
`define TPBS_CMD_SHR 2
`define TPBS_CMD_SCAN_END 3
// ==========================================================
// flag and interrupt bit positions
`define TPBS_FLG_LIMIT 0
`define TPBS_FLG_RANGE 1
`define TPBS_FLG_LASTBIT 2
`define TPBS_FLG_BUSY 3
`define TPBS_INT_DONE 3
// ==========================================================
// sizes and reset values
`define TPBS_WORD_BITS 16
`define TPBS_MEM_DEPTH 256
`define TPBS_RST_BYTE 8'h00
`define TPBS_RST_WORD 16'h0000
`define TPBS_RST_NIB 4'h0
`endif

// [hdl/tpbs_oct2bin.v]
// octal-coded shift count to binary converter
`default_nettype none
module tpbs_oct2bin (
    input wire [15:0] oct_in,
    output wire [11:0] bin_out
);
    // each nibble holds one octal digit; only its low three bits count
    assign bin_out = {oct_in[14:12], oct_in[10:8], oct_in[6:4], oct_in[2:0]};
endmodule // tpbs_oct2bin
`default_nettype wire

// [hdl/tpbs_unit.v]
// table push-to-top and whole-table bit shift execution unit
//
// Our own choices: the address map and strobed register access.
`include "tpbs_defines.vh"
`default_nettype none
module tpbs_unit (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [3:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    output reg irq_out
);
    // ======================================================
    // states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_PUSH = 4'b0010;
    localparam [3:0] ST_PCNT = 4'b0100;
    localparam [3:0] ST_SHIFT = 4'b1000;

    // ======================================================
    // storage
    // table memory is not reset; software presets what it uses
    reg [15:0] mem [0:`TPBS_MEM_DEPTH-1];
    reg [3:0] st_r;
    reg [7:0] start_r;
    reg [7:0] len_r;
    reg [7:0] src_r;
    reg [15:0] shcnt_r;
    reg [7:0] mem_addr_r;
    reg [7:0] idx_r;
    reg [15:0] ptr_r;
    reg [11:0] bits_left_r;
    reg carry_r;
    reg dir_left_r;
    reg flag_limit_r;
    reg flag_range_r;
    reg flag_last_r;
    reg [3:0] int_stat_r;
    reg [3:0] int_mask_r;

    wire wr_cmd = reg_wr_in && (reg_addr_in == `TPBS_REG_CMD);
    wire idle = st_r[0];
    wire [11:0] shift_bin;
    wire [11:0] total_bits = {len_r, 4'h0};
    wire [7:0] cur_addr = start_r + idx_r;
    wire [7:0] prev_addr = start_r + idx_r - 8'h01;
    wire [7:0] head_addr = start_r + 8'h01;
    // asynchronous table read; each cycle writes at most one word
    // limitation: addresses wrap at 256, so a table may roll over
    wire [15:0] cur_word = mem[cur_addr];
    wire [15:0] cnt_word = mem[start_r];
    wire [15:0] len_ext = {8'h00, len_r};
    wire [15:0] cnt_inc = ptr_r + 16'h0001;
    wire last_word = dir_left_r ? (idx_r == len_r - 8'h01)
                                : (idx_r == 8'h00);
    wire next_carry = dir_left_r ? cur_word[15] : cur_word[0];

    tpbs_oct2bin u_conv (
        .oct_in(shcnt_r),
        .bin_out(shift_bin)
    );

    // ======================================================
    // memory write port
    // software writes land only while idle, so one port suffices
    reg mem_we;
    reg [7:0] mem_wa;
    reg [15:0] mem_wd;
    always @* begin
        mem_we = 1'b0;
        mem_wa = 8'h00;
        mem_wd = 16'h0000;
        case (st_r)
            ST_IDLE: begin
                // software access only while no operation runs
                if (reg_wr_in && reg_addr_in == `TPBS_REG_MEM_DATA) begin
                    mem_we = 1'b1;
                    mem_wa = mem_addr_r;
                    mem_wd = reg_wdata_in;
                end
            end
            ST_PUSH: begin
                mem_we = 1'b1;
                // move from the bottom up so no entry is lost early
                if (idx_r > 8'h01) begin
                    mem_wa = cur_addr;
                    mem_wd = mem[prev_addr];
                end else begin
                    mem_wa = head_addr;
                    mem_wd = mem[src_r];
                end
            end
            ST_PCNT: begin
                mem_we = 1'b1;
                mem_wa = start_r;
                mem_wd = cnt_inc;
            end
            ST_SHIFT: begin
                mem_we = 1'b1;
                mem_wa = cur_addr;
                // one word per cycle, so n bits cost n passes of len cycles
                // slow for big counts, but no wide barrel shifter is needed
                // carry from the neighbour enters the far end
                if (dir_left_r) begin
                    mem_wd = {cur_word[14:0], carry_r};
                end else begin
                    mem_wd = {carry_r, cur_word[15:1]};
                end
            end
            default: begin
                mem_we = 1'b0;
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ======================================================
    // sequencer
    reg [3:0] ev_nxt;
    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_r <= ST_IDLE;
            idx_r <= `TPBS_RST_BYTE;
            ptr_r <= `TPBS_RST_WORD;
            bits_left_r <= 12'h000;
            carry_r <= 1'b0;
            dir_left_r <= 1'b0;
            flag_limit_r <= 1'b0;
            flag_range_r <= 1'b0;
            flag_last_r <= 1'b0;
        end else begin
            if (wr_cmd && reg_wdata_in[`TPBS_CMD_SCAN_END]) begin
                flag_limit_r <= 1'b0;
                flag_range_r <= 1'b0;
                flag_last_r <= 1'b0;
            end
            case (st_r)
                ST_IDLE: begin
                    // one issue runs the operation once
                    if (wr_cmd && reg_wdata_in[`TPBS_CMD_PUSH]) begin
                        ptr_r <= cnt_word;
                        flag_limit_r <=
                            (cnt_word == len_ext);
                        // counter at or past length stops pushes
                        if (cnt_word != 16'h0000 && cnt_word < len_ext) begin
                            st_r <= ST_PUSH;
                            idx_r <= len_r;
                        end
                    end else if (wr_cmd &&
                                 (reg_wdata_in[`TPBS_CMD_SHL] ||
                                  reg_wdata_in[`TPBS_CMD_SHR])) begin
                        dir_left_r <= reg_wdata_in[`TPBS_CMD_SHL];
                        flag_range_r <=
                            (shift_bin > total_bits);
                        flag_last_r <= 1'b0;
                        carry_r <= 1'b0;
                        bits_left_r <= shift_bin;
                        idx_r <= reg_wdata_in[`TPBS_CMD_SHL] ? 8'h00
                                 : len_r - 8'h01;
                        // out of range: table left as is
                        if (shift_bin <= total_bits &&
                            shift_bin != 12'h000) begin
                            st_r <= ST_SHIFT;
                        end
                    end
                end
                ST_PUSH: begin
                    if (idx_r > 8'h01) begin
                        idx_r <= idx_r - 8'h01;
                    end else begin
                        st_r <= ST_PCNT;
                    end
                end
                ST_PCNT: begin
                    flag_limit_r <= (cnt_inc == len_ext);
                    st_r <= ST_IDLE;
                end
                ST_SHIFT: begin
                    carry_r <= next_carry;
                    if (last_word) begin
                        // bit leaving the table end is dropped
                        carry_r <= 1'b0;
                        flag_last_r <= next_carry;
                        idx_r <= dir_left_r ? 8'h00 : len_r - 8'h01;
                        bits_left_r <= bits_left_r - 12'h001;
                        if (bits_left_r == 12'h001) begin
                            flag_last_r <= next_carry;
                            st_r <= ST_IDLE;
                        end
                    end else begin
                        idx_r <= dir_left_r ? idx_r + 8'h01
                                 : idx_r - 8'h01;
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // interrupt events
    // events pulse for one cycle; int_stat keeps them sticky
    always @* begin
        ev_nxt = 4'h0;
        ev_nxt[`TPBS_INT_DONE] = (st_r == ST_PCNT) ||
            (st_r == ST_SHIFT && last_word && bits_left_r == 12'h001);
        // a push that finds the table full reports the limit as well
        ev_nxt[`TPBS_FLG_LIMIT] = ((st_r == ST_PCNT) &&
            (cnt_inc == len_ext)) ||
            (idle && wr_cmd && reg_wdata_in[`TPBS_CMD_PUSH] &&
             cnt_word == len_ext);
        ev_nxt[`TPBS_FLG_RANGE] = idle && wr_cmd &&
            !reg_wdata_in[`TPBS_CMD_PUSH] &&
            (reg_wdata_in[`TPBS_CMD_SHL] || reg_wdata_in[`TPBS_CMD_SHR]) &&
            (shift_bin > total_bits);
        ev_nxt[`TPBS_FLG_LASTBIT] = (st_r == ST_SHIFT) && last_word &&
            (bits_left_r == 12'h001) && next_carry;
    end

    // ======================================================
    // register port
    wire [3:0] clr_w = (reg_wr_in && reg_addr_in == `TPBS_REG_INT_STAT)
                       ? reg_wdata_in[3:0] : 4'h0;
    wire [3:0] int_stat_nxt = (int_stat_r & ~clr_w) | ev_nxt;
    wire [3:0] int_mask_nxt =
        (reg_wr_in && reg_addr_in == `TPBS_REG_INT_MASK)
        ? reg_wdata_in[3:0] : int_mask_r;

    always @(posedge clk_in) begin
        if (sys_rst_in) begin
            start_r <= `TPBS_RST_BYTE;
            len_r <= `TPBS_RST_BYTE;
            src_r <= `TPBS_RST_BYTE;
            shcnt_r <= `TPBS_RST_WORD;
            mem_addr_r <= `TPBS_RST_BYTE;
            int_stat_r <= `TPBS_RST_NIB;
            int_mask_r <= `TPBS_RST_NIB;
            reg_rdata_out <= `TPBS_RST_WORD;
            irq_out <= 1'b0;
        end else begin
            // set wins over a simultaneous write-one clear
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            irq_out <= |(int_stat_nxt & int_mask_nxt);
            // operands frozen while busy so a run stays consistent
            if (reg_wr_in && idle) begin
                case (reg_addr_in)
                    `TPBS_REG_ACC: start_r <= reg_wdata_in[7:0];
                    `TPBS_REG_STK1: len_r <= reg_wdata_in[7:0];
                    `TPBS_REG_SRC: src_r <= reg_wdata_in[7:0];
                    `TPBS_REG_SHCNT: shcnt_r <= reg_wdata_in;
                    `TPBS_REG_MEM_ADDR: mem_addr_r <= reg_wdata_in[7:0];
                    default: mem_addr_r <= mem_addr_r;
                endcase
            end
            // read data stand one cycle, then drop back to zero
            reg_rdata_out <= 16'h0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `TPBS_REG_ACC: reg_rdata_out <= {8'h00, start_r};
                    `TPBS_REG_STK1: reg_rdata_out <= {8'h00, len_r};
                    `TPBS_REG_SRC: reg_rdata_out <= {8'h00, src_r};
                    `TPBS_REG_SHCNT: reg_rdata_out <= shcnt_r;
                    `TPBS_REG_FLAGS: reg_rdata_out <= {12'h000, !idle,
                        flag_last_r, flag_range_r, flag_limit_r};
                    `TPBS_REG_INT_STAT: reg_rdata_out <= {12'h000, int_stat_r};
                    `TPBS_REG_INT_MASK: reg_rdata_out <= {12'h000, int_mask_r};
                    `TPBS_REG_MEM_ADDR: reg_rdata_out <= {8'h00, mem_addr_r};
                    `TPBS_REG_MEM_DATA: reg_rdata_out <= mem[mem_addr_r];
                    default: reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end
endmodule // tpbs_unit
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the table push and bit shift unit
`include "tpbs_defines.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, v;
    logic wr, rd, irq;
    int num_errors = 0;
    int checks = 0;
    always #50 clk = ~clk;
    tpbs_scan_eng eng (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    tpbs_unit uut (.clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .irq_out(irq));
    // ==========================================================
    // compare and access helpers
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(string n, logic [3:0] a, logic [15:0] e);
        eng.rd(a, v);
        chk(n, e, v);
    endtask
    task automatic mchk(string n, logic [7:0] a, logic [15:0] e);
        eng.wr(`TPBS_REG_MEM_ADDR, {8'h00, a});
        rchk(n, `TPBS_REG_MEM_DATA, e);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // polling is bounded so a stuck busy flag ends the run
    task automatic go(logic [15:0] c);
        int i;
        eng.wr(`TPBS_REG_CMD, c);
        for (i = 0; i < 2000; i++) begin
            eng.rd(`TPBS_REG_FLAGS, v);
            if (v[`TPBS_FLG_BUSY] === 1'b0)
                break;
        end
        if (i == 2000) begin
            num_errors++;
            finish_test();
        end
    endtask
    // ==========================================================
    // scenarios
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk("unmapped", 4'hc, 16'h0000);
        rchk("cmd", `TPBS_REG_CMD, 16'h0000);
        eng.setup(8'h10, 8'h03);
        eng.mem_wr(8'h10, 16'h0001);
        eng.mem_wr(8'h11, 16'haaaa);
        eng.mem_wr(8'h12, 16'hbbbb);
        eng.mem_wr(8'h40, 16'h1234);
        eng.wr(`TPBS_REG_SRC, 16'h0040);
        rchk("acc", `TPBS_REG_ACC, 16'h0010);
        rchk("len", `TPBS_REG_STK1, 16'h0003);
        rchk("src", `TPBS_REG_SRC, 16'h0040);
        go(16'h0001);
        mchk("head", 8'h11, 16'h1234);
        mchk("entry", 8'h12, 16'haaaa);
        mchk("tail", 8'h13, 16'hbbbb);
        mchk("counter", 8'h10, 16'h0002);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        rchk("stat", `TPBS_REG_INT_STAT, 16'h0008);
        eng.wr(`TPBS_REG_INT_MASK, 16'h0008);
        rchk("mask", `TPBS_REG_INT_MASK, 16'h0008);
        chk("irq", 16'h0001, {15'h0000, irq});
        eng.wr(`TPBS_REG_INT_STAT, 16'h0008);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        eng.wr(`TPBS_REG_INT_MASK, 16'h0000);
        eng.mem_wr(8'h40, 16'h5678);
        go(16'h0001);
        mchk("head", 8'h11, 16'h5678);
        mchk("entry", 8'h12, 16'h1234);
        mchk("tail", 8'h13, 16'haaaa);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0001);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h0009);
        eng.wr(`TPBS_REG_INT_STAT, 16'h000f);
        go(16'h0001);
        mchk("counter", 8'h10, 16'h0003);
        mchk("head", 8'h11, 16'h5678);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h0001);
        eng.wr(`TPBS_REG_INT_STAT, 16'h000f);
        go(16'h0008);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0000);
        eng.mem_wr(8'h10, 16'h0000);
        go(16'h0001);
        mchk("head", 8'h11, 16'h5678);
        mchk("counter", 8'h10, 16'h0000);
        eng.mem_wr(8'h10, 16'h0005);
        go(16'h0001);
        mchk("head", 8'h11, 16'h5678);
        $display("push test done");
        eng.setup(8'h20, 8'h02);
        eng.mem_wr(8'h20, 16'h8001);
        eng.mem_wr(8'h21, 16'h0001);
        eng.wr(`TPBS_REG_SHCNT, 16'h0021);
        rchk("shcnt", `TPBS_REG_SHCNT, 16'h0021);
        eng.wr(`TPBS_REG_CMD, 16'h0002);
        eng.wr(`TPBS_REG_ACC, 16'h0055);
        go(16'h0000);
        rchk("frozen", `TPBS_REG_ACC, 16'h0020);
        mchk("low", 8'h20, 16'h0000);
        mchk("high", 8'h21, 16'h0002);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0004);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h000c);
        eng.wr(`TPBS_REG_INT_STAT, 16'h000f);
        eng.mem_wr(8'h20, 16'h0004);
        eng.mem_wr(8'h21, 16'h0003);
        eng.wr(`TPBS_REG_SHCNT, 16'h0002);
        go(16'h0004);
        mchk("low", 8'h20, 16'hc001);
        mchk("high", 8'h21, 16'h0000);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0000);
        eng.wr(`TPBS_REG_SHCNT, 16'h0041);
        go(16'h0002);
        rchk("flags", `TPBS_REG_FLAGS, 16'h0002);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h000a);
        mchk("low", 8'h20, 16'hc001);
        mchk("high", 8'h21, 16'h0000);
        $display("shift test done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rchk("acc", `TPBS_REG_ACC, 16'h0000);
        rchk("stat", `TPBS_REG_INT_STAT, 16'h0000);
        chk("irq", 16'h0000, {15'h0000, irq});
        $display("reset test done");
        finish_test();
    end
endmodule // tb
`default_nettype wire

// [testbench/tpbs_chk.sv]
// bus and interrupt checker for the table push and bit shift unit
`default_nettype none
module tpbs_chk (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_rdata_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 0)
        else $error("read data outside read slot");
    a_reset_quiet: assert property ($fell(sys_rst_in) |-> !irq_out &&
        reg_rdata_out == 16'h0000) else $error("outputs not clear at reset");
    a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 4'h9
        |=> reg_rdata_out == 16'h0000) else $error("unmapped read not zero");
    a_cmd_write_only: assert property (reg_rd_in && reg_addr_in == 4'h0
        |=> reg_rdata_out == 16'h0000) else $error("command reads back");
    a_flags_width: assert property (reg_rd_in && reg_addr_in == 4'h5
        |=> reg_rdata_out[15:4] == 12'h000) else $error("flags upper bits");
    a_stat_width: assert property (reg_rd_in && reg_addr_in inside {6, 7}
        |=> reg_rdata_out[15:4] == 12'h000) else $error("irq reg upper bits");
    a_mask_off: assert property (reg_wr_in && reg_addr_in == 4'h7 &&
        reg_wdata_in[3:0] == 4'h0 |=> !irq_out) else $error("masked irq high");
    a_mask_readback: assert property (reg_wr_in && reg_addr_in == 4'h7 ##1
        !reg_wr_in ##1 reg_rd_in && reg_addr_in == 4'h7 |=>
        reg_rdata_out[3:0] == $past(reg_wdata_in[3:0], 3))
        else $error("mask readback wrong");
endmodule // tpbs_chk
bind tpbs_unit tpbs_chk chk (.clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);
`default_nettype wire

// [testbench/tpbs_scan_eng.sv]
// scan engine model issuing table operations over the register port
`include "tpbs_defines.vh"
`default_nettype none
module tpbs_scan_eng (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output var logic [3:0] addr_out,
    output var logic [15:0] wdata_out,
    output var logic wr_out,
    output var logic rd_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr_out = 4'h0;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    // ==========================================================
    // bus cycles: one strobe per call, one scan pulse each
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d; // released data must not look stale
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        // the answer stands in the next cycle; take it at its closing edge
        @(posedge clk_in);
        d = rdata_in;
    endtask
    // length to stack, start to accumulator before any issue
    task automatic setup(input logic [7:0] s, input logic [7:0] n);
        wr(`TPBS_REG_ACC, {8'h00, s});
        wr(`TPBS_REG_STK1, {8'h00, n});
    endtask
    // the program presets the counter word itself
    task automatic mem_wr(input logic [7:0] a, input logic [15:0] d);
        wr(`TPBS_REG_MEM_ADDR, {8'h00, a});
        wr(`TPBS_REG_MEM_DATA, d);
    endtask
endmodule // tpbs_scan_eng
`default_nettype wire
